// [src/jtapi_pkg.sv]
// constants, opcodes, state and register layout of the test port block
// assumes one 20 MHz system clock that samples the slow test clock pin
// Notes on behaviour
// - boundary test pin control is suppressed while configuration runs
// - four test pins plus optional active-low test reset; device drives tdo
// - instruction register is ten bits, loaded serially from tdi
// - sample/preload captures pin values and preloads the scan register
// - extest drives scan register onto outputs and captures the inputs
// - bypass puts one-bit register between tdi and tdo
// - usercode puts 32-bit user code register between tdi and tdo
// - idcode puts identification register between tdi and tdo
// - id code is version, part number, manufacturer, then lsb one
// - highz uses bypass path and tri-states every i/o pin
// - clamp uses bypass path while pins hold scan register levels
// - reconfig opcode acts like a low pulse on the reconfig request pin
// - io standard opcode loads settings anytime, aborts running configuration
// - config status held low until io settings loaded and update-dr reached
// - io standard settings update any time before or during user mode
// - bus hold or pull-up overrides high impedance of highz, clamp, extest; here only highz, as clamp and extest drive every pin
`default_nettype none
package jtapi_pkg;
  // register lengths
  localparam int unsigned IR_LEN    = 10;
  localparam int unsigned ID_LEN    = 32;
  localparam int unsigned BSR_LEN   = 8;
  localparam int unsigned IOSTD_LEN = 8;

  // instruction opcodes
  localparam logic [IR_LEN-1:0] OP_SAMPLE     = 10'h005;
  localparam logic [IR_LEN-1:0] OP_EXTEST     = 10'h00f;
  localparam logic [IR_LEN-1:0] OP_BYPASS     = 10'h3ff;
  localparam logic [IR_LEN-1:0] OP_USERCODE   = 10'h007;
  localparam logic [IR_LEN-1:0] OP_IDCODE     = 10'h006;
  localparam logic [IR_LEN-1:0] OP_HIGHZ      = 10'h00b;
  localparam logic [IR_LEN-1:0] OP_CLAMP      = 10'h00a;
  localparam logic [IR_LEN-1:0] OP_PULSE_RCFG = 10'h001;
  localparam logic [IR_LEN-1:0] OP_CONFIG_IO  = 10'h00d;
  localparam logic [IR_LEN-1:0] IR_CAPTURE    = 10'h001;

  // identification fields; values are arbitrary
  localparam logic [3:0]        ID_VERSION = 4'h1;
  localparam logic [15:0]       ID_PART    = 16'h5a5a;
  localparam logic [10:0]       ID_MFR     = 11'h0ab;
  localparam logic [ID_LEN-1:0] ID_CODE    = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
  localparam logic [ID_LEN-1:0] ID_ZERO    = 32'h0000_0000;

  typedef enum logic [15:0] {
    ST_RESET    = 16'h0001, ST_IDLE     = 16'h0002, ST_SEL_DR  = 16'h0004,
    ST_CAP_DR   = 16'h0008, ST_SHIFT_DR = 16'h0010, ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040, ST_EXIT2_DR = 16'h0080, ST_UPD_DR  = 16'h0100,
    ST_SEL_IR   = 16'h0200, ST_CAP_IR   = 16'h0400, ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000, ST_PAUSE_IR = 16'h2000, ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR   = 16'h8000
  } jtapi_tap_e;

  typedef enum logic [4:0] {
    DR_BYP = 5'h01, DR_ID = 5'h02, DR_USER = 5'h04, DR_BSR = 5'h08, DR_IOSTD = 5'h10
  } jtapi_dr_e;

  typedef struct packed {
    logic [2:0]           tck_s;
    logic [1:0]           tms_s;
    logic [1:0]           tdi_s;
    logic [1:0]           trst_s;
    logic [BSR_LEN-1:0]   pin_s0;
    logic [BSR_LEN-1:0]   pin_s1;
    jtapi_tap_e           tap;
    logic [IR_LEN-1:0]    ir_sh;
    logic [IR_LEN-1:0]    ir;
    logic [ID_LEN-1:0]    dr_sh;
    logic                 byp;
    logic [BSR_LEN-1:0]   bsr_sh;
    logic [BSR_LEN-1:0]   bsr_upd;
    logic [IOSTD_LEN-1:0] iostd_sh;
    logic [IOSTD_LEN-1:0] iostd;
    logic                 io_loaded;
    logic                 cfg_hold;
    logic                 tdo;
    logic                 tdo_oe;
    logic                 rcfg_pulse;
    logic                 abort;
  } jtapi_state_s;
endpackage
`default_nettype wire

// [src/jtapi_tap.sv]
// test access port: tap machine, instruction and data registers, pin control
// assumes test pins are asynchronous; core-side inputs are on clk_i
`default_nettype none
module jtapi_tap
  import jtapi_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 tck_i,
  input  wire logic                 tms_i,
  input  wire logic                 tdi_i,
  input  wire logic                 trst_n_i,
  output logic                      tdo_o,
  output logic                      tdo_oe_o,
  input  wire logic [ID_LEN-1:0]    usercode_i,
  input  wire logic                 config_busy_i,
  input  wire logic [BSR_LEN-1:0]   pin_in_i,
  input  wire logic [BSR_LEN-1:0]   core_out_i,
  input  wire logic [BSR_LEN-1:0]   core_oe_i,
  input  wire logic [BSR_LEN-1:0]   keeper_en_i,
  output logic [BSR_LEN-1:0]        pin_out_o,
  output logic [BSR_LEN-1:0]        pin_oe_o,
  output logic [BSR_LEN-1:0]        pin_keep_o,
  output logic [IOSTD_LEN-1:0]      io_std_o,
  output logic                      config_status_oe_o,
  output logic                      reconfig_pulse_o,
  output logic                      config_abort_o
);
  jtapi_state_s q, d;
  jtapi_tap_e   nxt;
  jtapi_dr_e    sel;
  logic         rise, fall, tms, tdi;
  logic         bs_drive, hiz;

  // standard tap sequencing on tms
  function automatic jtapi_tap_e tap_next(input jtapi_tap_e s, input logic m);
    unique case (s)
      ST_RESET:    tap_next = m ? ST_RESET   : ST_IDLE;
      ST_IDLE:     tap_next = m ? ST_SEL_DR  : ST_IDLE;
      ST_SEL_DR:   tap_next = m ? ST_SEL_IR  : ST_CAP_DR;
      ST_CAP_DR:   tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: tap_next = m ? ST_UPD_DR  : ST_PAUSE_DR;
      ST_PAUSE_DR: tap_next = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: tap_next = m ? ST_UPD_DR  : ST_SHIFT_DR;
      ST_UPD_DR:   tap_next = m ? ST_SEL_DR  : ST_IDLE;
      ST_SEL_IR:   tap_next = m ? ST_RESET   : ST_CAP_IR;
      ST_CAP_IR:   tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: tap_next = m ? ST_UPD_IR  : ST_PAUSE_IR;
      ST_PAUSE_IR: tap_next = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: tap_next = m ? ST_UPD_IR  : ST_SHIFT_IR;
      ST_UPD_IR:   tap_next = m ? ST_SEL_DR  : ST_IDLE;
      default:     tap_next = ST_RESET;
    endcase
  endfunction

  // data register chosen by the current instruction
  function automatic jtapi_dr_e dr_select(input logic [IR_LEN-1:0] op);
    unique case (op)
      OP_IDCODE:             dr_select = DR_ID;
      OP_USERCODE:           dr_select = DR_USER;
      OP_SAMPLE, OP_EXTEST:  dr_select = DR_BSR;
      OP_CONFIG_IO:          dr_select = DR_IOSTD;
      default:               dr_select = DR_BYP;
    endcase
  endfunction

  // edge detection on the synchronised test clock
  always_comb begin
    rise = q.tck_s[1] & ~q.tck_s[2];
    fall = ~q.tck_s[1] & q.tck_s[2];
    tms  = q.tms_s[1];
    tdi  = q.tdi_s[1];
    sel  = dr_select(q.ir);
    nxt  = tap_next(q.tap, tms);
  end

  // next state of the whole block
  always_comb begin
    d            = q;
    d.tck_s      = {q.tck_s[1:0], tck_i};
    d.tms_s      = {q.tms_s[0], tms_i};
    d.tdi_s      = {q.tdi_s[0], tdi_i};
    d.trst_s     = {q.trst_s[0], trst_n_i};
    // pin levels come from outside the clock domain: two flops first
    d.pin_s0     = pin_in_i;
    d.pin_s1     = q.pin_s0;
    d.rcfg_pulse = 1'b0;
    d.abort      = 1'b0;
    if (!q.trst_s[1]) begin
      d.tap = ST_RESET;
    end else if (rise) begin
      d.tap = nxt;
      unique case (q.tap)
        ST_CAP_IR:   d.ir_sh = IR_CAPTURE;
        ST_SHIFT_IR: d.ir_sh = {tdi, q.ir_sh[IR_LEN-1:1]};
        ST_CAP_DR: begin
          unique case (sel)
            DR_BYP:   d.byp      = 1'b0;
            DR_ID:    d.dr_sh    = ID_CODE;
            DR_USER:  d.dr_sh    = usercode_i;
            DR_BSR:   d.bsr_sh   = q.pin_s1;
            DR_IOSTD: d.iostd_sh = q.iostd;
          endcase
        end
        ST_SHIFT_DR: begin
          unique case (sel)
            DR_BYP:       d.byp   = tdi;
            DR_ID, DR_USER: d.dr_sh = {tdi, q.dr_sh[ID_LEN-1:1]};
            DR_BSR:       d.bsr_sh = {tdi, q.bsr_sh[BSR_LEN-1:1]};
            DR_IOSTD: begin
              d.iostd_sh  = {tdi, q.iostd_sh[IOSTD_LEN-1:1]};
              d.io_loaded = 1'b1;
            end
          endcase
        end
        default: ;
      endcase
      // update actions as the machine enters an update state
      if (nxt == ST_UPD_IR) begin
        d.ir = q.ir_sh;
        if (q.ir_sh == OP_PULSE_RCFG) begin
          d.rcfg_pulse = 1'b1;
        end
        if (q.ir_sh == OP_CONFIG_IO) begin
          d.cfg_hold  = 1'b1;
          d.io_loaded = 1'b0;
          d.abort     = config_busy_i;
        end
      end
      if (nxt == ST_UPD_DR) begin
        if (sel == DR_BSR) begin
          d.bsr_upd = q.bsr_sh;
        end
        if (sel == DR_IOSTD) begin
          d.iostd = q.iostd_sh;
          if (q.io_loaded || (q.tap == ST_EXIT1_DR && q.io_loaded)) begin
            d.cfg_hold = 1'b0;
          end
        end
      end
    end
    // reset state forces idcode and drops the io standard hold
    if (d.tap == ST_RESET) begin
      d.ir       = OP_IDCODE;
      d.cfg_hold = 1'b0;
    end
    // tdo changes on the falling test clock edge
    if (fall) begin
      d.tdo_oe = (q.tap == ST_SHIFT_IR) || (q.tap == ST_SHIFT_DR);
      if (q.tap == ST_SHIFT_IR) begin
        d.tdo = q.ir_sh[0];
      end else begin
        unique case (sel)
          DR_BYP:         d.tdo = q.byp;
          DR_ID, DR_USER: d.tdo = q.dr_sh[0];
          DR_BSR:         d.tdo = q.bsr_sh[0];
          DR_IOSTD:       d.tdo = q.iostd_sh[0];
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q         <= '0;
      q.tap     <= ST_RESET;
      q.ir      <= OP_IDCODE;
      q.trst_s  <= '1;
    end else begin
      q <= d;
    end
  end

  // pin control under boundary test instructions
  always_comb begin
    bs_drive   = !config_busy_i && (q.ir == OP_EXTEST || q.ir == OP_CLAMP);
    hiz        = !config_busy_i && (q.ir == OP_HIGHZ);
    pin_out_o  = bs_drive ? q.bsr_upd : core_out_i;
    pin_oe_o   = hiz ? '0 : (bs_drive ? '1 : core_oe_i);
    pin_keep_o = keeper_en_i & ~pin_oe_o;
  end

  assign tdo_o              = q.tdo;
  assign tdo_oe_o           = q.tdo_oe;
  assign io_std_o           = q.iostd;
  assign config_status_oe_o = q.cfg_hold;
  assign reconfig_pulse_o   = q.rcfg_pulse;
  assign config_abort_o     = q.abort;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_io_issue;
    rise && q.trst_s[1] && nxt == ST_UPD_IR && q.ir_sh == OP_CONFIG_IO;
  endsequence

  a_trst_forces_reset: assert property (!q.trst_s[1] |=> q.tap == ST_RESET)
    else $error("tap not reset by test reset");
  a_reset_loads_id: assert property (q.tap == ST_RESET |-> q.ir == OP_IDCODE)
    else $error("reset state without idcode");
  a_ir_update_load: assert property (
      rise && q.trst_s[1] && nxt == ST_UPD_IR |=> q.ir == $past(q.ir_sh))
    else $error("instruction not loaded");
  a_id_lsb_one: assert property (
      rise && q.trst_s[1] && q.tap == ST_CAP_DR && sel == DR_ID |=> q.dr_sh[0])
    else $error("id code lsb not one");
  a_bypass_capture: assert property (
      rise && q.trst_s[1] && q.tap == ST_CAP_DR && sel == DR_BYP |=> !q.byp)
    else $error("bypass capture not zero");
  a_highz_all_off: assert property (q.ir == OP_HIGHZ && !config_busy_i |-> pin_oe_o == '0)
    else $error("pins driven under highz");
  a_clamp_holds: assert property (
      q.ir == OP_CLAMP && !config_busy_i |-> pin_out_o == q.bsr_upd && pin_oe_o == '1)
    else $error("clamp pins not from scan register");
  a_busy_no_test: assert property (
      config_busy_i |-> pin_out_o == core_out_i && pin_oe_o == core_oe_i)
    else $error("boundary test active during configuration");
  a_tdo_enable: assert property (
      fall |=> tdo_oe_o == ($past(q.tap) == ST_SHIFT_IR || $past(q.tap) == ST_SHIFT_DR))
    else $error("tdo enable outside shift states");
  a_pulse_one_cycle: assert property (reconfig_pulse_o |=> !reconfig_pulse_o)
    else $error("reconfig pulse too long");
  a_io_hold_sets: assert property (s_io_issue |=> config_status_oe_o)
    else $error("status not held after io instruction");
  a_abort_on_busy: assert property (s_io_issue ##0 config_busy_i |=> config_abort_o)
    else $error("configuration not aborted");
  a_keeper_override: assert property (hiz |-> pin_keep_o == keeper_en_i)
    else $error("keeper not applied");
endmodule
`default_nettype wire

// [testbench/jtapi_ctrl_model.sv]
// external test controller model: drives tck, tms, tdi, trst, reads tdo
// assumes a single device in the chain, well inside the allowed places
// tck idles low between frames
`default_nettype none
module jtapi_ctrl_model
  import jtapi_pkg::*;
(
  output var logic tck_o,
  output var logic tms_o,
  output var logic tdi_o,
  output var logic trst_n_o,
  input  wire logic tdo_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels: tck low, pulled-up lines high
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b1;
  end
  // one 400 ns tck period; tdo read late in the high phase
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #200 tck_o = 1'b1;
    #190 tdo = tdo_i;
    #10 tck_o = 1'b0;
  endtask
  // ones on tms reset the tap, then one zero goes to idle
  task automatic to_idle(input int ones);
    logic t;
    repeat (ones) tick(1'b1, 1'b1, t);
    tick(1'b0, 1'b1, t);
  endtask
  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic t;
    dout = 32'h0000_0000;
    tick(1'b1, 1'b1, t);
    if (is_ir) tick(1'b1, 1'b1, t);
    tick(1'b0, 1'b1, t);
    tick(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], t);
      dout[i] = t;
    end
    // past the frame tdi shows the inverse of its last bit
    tick(1'b1, ~din[n-1], t);
    tick(1'b0, ~din[n-1], t);
    tdi_o = 1'b1;
  endtask
  // optional test reset pulse
  task automatic trst_pulse();
    trst_n_o = 1'b0;
    #500 trst_n_o = 1'b1;
    #500;
  endtask
endmodule
`default_nettype wire

// [testbench/jtag_tap_instruction_logic_bench.sv]
// bench of the test port: scenarios per instruction, controller model
// assumes 20 MHz clk_i and a 400 ns tck from the model
`default_nettype none
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module jtag_tap_instruction_logic_bench
  import jtapi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_i, nrst_i, tck, tms, tdi, trst_n, tdo, tdo_oe, busy;
  logic                 st_oe, rcfg, abrt;
  logic [ID_LEN-1:0]    ucode, r;
  logic [BSR_LEN-1:0]   pin_in, c_out, c_oe, keep_en, p_out, p_oe, p_keep;
  logic [IOSTD_LEN-1:0] io_std;
  int                   mismatches, checks, n_rcfg, n_abrt;
  jtapi_ctrl_model ctrl_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
                           .tdo_i(tdo));
  jtapi_tap dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .usercode_i(ucode),
    .config_busy_i(busy), .pin_in_i(pin_in), .core_out_i(c_out), .core_oe_i(c_oe),
    .keeper_en_i(keep_en), .pin_out_o(p_out), .pin_oe_o(p_oe), .pin_keep_o(p_keep),
    .io_std_o(io_std), .config_status_oe_o(st_oe), .reconfig_pulse_o(rcfg),
    .config_abort_o(abrt));
  // clock and pulse counters
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (rcfg === 1'b1) n_rcfg++;
    if (abrt === 1'b1) n_abrt++;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge clk_i);
    #2;
  endtask
  task automatic ld(input logic [IR_LEN-1:0] op);
    ctrl_u.scan(1'b1, IR_LEN, {22'h00_0000, op}, r);
  endtask
  task automatic t_reset();
    `CHK("tdo_oe", 1'b0, tdo_oe)
    `CHK("io_std", 8'h00, io_std)
    `CHK("status", 1'b0, st_oe)
    ctrl_u.to_idle(5);
    ctrl_u.scan(1'b0, ID_LEN, 32'h0000_0000, r);
    `CHK("idcode", ID_CODE, r)
    `CHK("id lsb", 1'b1, r[0])
    ld(OP_SAMPLE);
    `CHK("ir capture", IR_CAPTURE, r[9:0])
    $display("test reset done");
  endtask
  task automatic t_sample();
    step();
    pin_in = 8'h96;
    ctrl_u.scan(1'b0, BSR_LEN, 32'h0000_003c, r);
    `CHK("sample cap", 8'h96, r[7:0])
    `CHK("sample pins", c_out, p_out)
    ld(OP_EXTEST);
    `CHK("preload out", 8'h3c, p_out)
    `CHK("extest oe", 8'hff, p_oe)
    step();
    pin_in = 8'h5a;
    ctrl_u.scan(1'b0, BSR_LEN, 32'h0000_00c3, r);
    `CHK("extest cap", 8'h5a, r[7:0])
    `CHK("extest out", 8'hc3, p_out)
    step();
    busy = 1'b1;
    step();
    `CHK("busy out", c_out, p_out)
    `CHK("busy oe", c_oe, p_oe)
    busy = 1'b0;
    $display("test sample extest done");
  endtask
  task automatic t_bypass();
    logic [IR_LEN-1:0] ops [4];
    ops = '{OP_BYPASS, OP_HIGHZ, OP_CLAMP, 10'h155};
    foreach (ops[k]) begin
      ld(ops[k]);
      ctrl_u.scan(1'b0, 16, 32'h0000_c3a5, r);
      `CHK("bypass", 16'h874a, r[15:0])
      if (ops[k] == OP_HIGHZ) begin
        `CHK("highz oe", 8'h00, p_oe)
        `CHK("keeper", keep_en, p_keep)
      end
      if (ops[k] == OP_CLAMP) `CHK("clamp out", 8'hc3, p_out)
    end
    $display("test bypass done");
  endtask
  task automatic t_ident();
    ld(OP_USERCODE);
    ctrl_u.scan(1'b0, ID_LEN, 32'h0000_0000, r);
    `CHK("usercode", ucode, r)
    ld(OP_BYPASS);
    ctrl_u.trst_pulse();
    ctrl_u.to_idle(0);
    ctrl_u.scan(1'b0, ID_LEN, 32'h0000_0000, r);
    `CHK("trst idcode", ID_CODE, r)
    $display("test ident done");
  endtask
  task automatic t_config();
    n_rcfg = 0;
    ld(OP_PULSE_RCFG);
    `CHK("reconfig", 1, n_rcfg)
    step();
    busy = 1'b1;
    n_abrt = 0;
    ld(OP_CONFIG_IO);
    `CHK("abort", 1, n_abrt)
    `CHK("status low", 1'b1, st_oe)
    ctrl_u.scan(1'b0, IOSTD_LEN, 32'h0000_00a7, r);
    `CHK("io std", 8'ha7, io_std)
    `CHK("status rel", 1'b0, st_oe)
    `CHK("reconfig once", 1, n_rcfg)
    busy = 1'b0;
    $display("test config done");
  endtask
  // bounded run time
  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end
  initial begin
    nrst_i = 1'b0;
    busy = 1'b0;
    ucode = 32'h1234_5678;
    pin_in = 8'h00;
    c_out = 8'h69;
    c_oe = 8'h0f;
    keep_en = 8'h33;
    repeat (3) @(posedge clk_i);
    #2 nrst_i = 1'b1;
    t_reset();
    t_sample();
    t_bypass();
    t_ident();
    t_config();
    end_sim();
  end
endmodule
`undef CHK
`default_nettype wire
